// ### include/rtsw_pkg.sv
// Package for the reset and trim status word block.
// Assumes a single clock domain and a host access port that presents
// one request per cycle (read or write strobe with a word address).
`default_nettype none

package rtsw_pkg;

	// Width of the word address carried by the access port
	localparam int unsigned ADDR_W            = 7;
	// Width of the status word as seen by the host
	localparam int unsigned WORD_W            = 10;
	// Width of the factory booster offset trim code
	localparam int unsigned TRIM_W            = 5;

	// Address of the reset and trim status word
	localparam logic [ADDR_W-1:0] RESET_AND_TRIM_STATUS_ADDR = 7'h19;

	// Field positions inside the status word
	localparam int unsigned TRIM_LSB          = 0;
	localparam int unsigned TRIM_MSB          = 4;
	localparam int unsigned RST_FLAG_POS      = 5;
	localparam int unsigned UNUSED_LO_LSB     = 6;
	localparam int unsigned UNUSED_LO_MSB     = 7;
	localparam int unsigned PARITY_POS        = 8;
	localparam int unsigned UNUSED_HI_POS     = 9;

	// Value of the power-up reset flag after power-on reset
	localparam logic        RST_FLAG_RESET    = 1'h1;
	// Value of the unused positions on every read
	localparam logic [1:0]  UNUSED_LO_VALUE   = 2'h0;
	localparam logic        UNUSED_HI_VALUE   = 1'h0;
	// Value of read data and strobes after reset
	localparam logic [WORD_W-1:0] WORD_RESET  = 10'h000;
	localparam logic        STROBE_RESET      = 1'h0;

	// Cycles from a taken read to its answer on the port
	localparam int unsigned READ_LATENCY      = 1;

	// One access from the host side, taken in a single cycle
	typedef struct packed {
		logic              rd;    // Read strobe, one cycle
		logic              wr;    // Write strobe, one cycle
		logic [ADDR_W-1:0] addr;  // Word address
	} rtsw_req_s;

	// Answer returned to the host side
	typedef struct packed {
		logic              valid;   // Read answer present
		logic              refused; // Write aimed at this word dropped
		logic [WORD_W-1:0] data;    // Read data
	} rtsw_rsp_s;

endpackage

`default_nettype wire

// ### hw/rtsw_odd_parity.sv
// Odd parity generator for the status word.
// Assumes the caller passes every reported bit except the parity bit itself.
`timescale 1ns/100ps
`default_nettype none

module rtsw_odd_parity #(
	parameter int unsigned WIDTH = 9  // Bits covered, parity bit excluded
) (
	input  wire logic [WIDTH-1:0] i_bits,    // Bits covered by the parity
	output logic                  o_parity   // Bit that makes the total odd
);

	// Odd parity: set when the covered bits hold an even count of ones,
	// so that covered bits plus parity always carry an odd count
	always_comb begin
		o_parity = ~(^i_bits);
	end

endmodule

`default_nettype wire

// ### hw/rtsw_status_word.sv
// Reset and trim status word: a read-only ten-bit word in the register map.
// Assumes the host access port is decoded upstream into one read or write
// strobe per cycle with a word address, all on i_clk, and that the trim
// code comes from factory fuse logic on the same clock.
//
// Notes on behaviour
// - Bits 4:0 show live factory trim code
// - Bit 5 latched reset flag, powers up one
// - Bits 7 and 6 always read zero
// - Bit 8 makes total ones count odd
// - Bit 9 always reads zero
`timescale 1ns/100ps
`default_nettype none

module rtsw_status_word #(
	parameter int unsigned TRIM_W = rtsw_pkg::TRIM_W  // Trim code width
) (
	input  wire logic                            i_clk,           // 40 MHz clock
	input  wire logic                            i_rst,           // Async reset
	input  wire rtsw_pkg::rtsw_req_s             i_req,           // Host access
	input  wire logic [TRIM_W-1:0]               i_trim_code,     // Factory trim
	output logic [rtsw_pkg::WORD_W-1:0]          o_rd_data,       // Read data
	output logic                                 o_rd_valid,      // Read answer
	output logic                                 o_wr_refused,    // Write dropped
	output logic [rtsw_pkg::WORD_W-1:0]          o_status_word,   // Live word
	output logic                                 o_power_up_reset_flag // Flag
);

	// Latched power-up reset flag
	logic                          power_up_reset_flag_r;
	// Word as it would be read in this cycle
	logic [rtsw_pkg::WORD_W-1:0]   word_now;
	// Bits covered by parity, parity position left out
	logic [rtsw_pkg::WORD_W-2:0]   parity_cover;
	// Parity bit from the generator
	logic                          parity_bit;
	// Access decoded to this word
	logic                          addr_hit;
	logic                          rd_hit;
	logic                          wr_hit;
	// Next values of the port registers
	logic [rtsw_pkg::WORD_W-1:0]   rd_data_nxt;
	logic                          rd_valid_nxt;
	logic                          wr_refused_nxt;
	// Port registers
	logic [rtsw_pkg::WORD_W-1:0]   rd_data_r;
	logic                          rd_valid_r;
	logic                          wr_refused_r;
	logic [rtsw_pkg::WORD_W-1:0]   status_word_r;

	// Address match against the one address this block owns
	function automatic logic match_addr(input logic [rtsw_pkg::ADDR_W-1:0] addr);
		match_addr = (addr == rtsw_pkg::RESET_AND_TRIM_STATUS_ADDR);
	endfunction

	// Access decode
	always_comb begin
		addr_hit = match_addr(i_req.addr);
		// Read wins if a broken master raises both strobes
		rd_hit   = i_req.rd & addr_hit;
		wr_hit   = i_req.wr & ~i_req.rd & addr_hit;
	end

	// Power-up reset flag
	// The flag is set by the reset itself and nothing in this block clears
	// it; a write must not disturb it, so the register has no write path.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			power_up_reset_flag_r <= rtsw_pkg::RST_FLAG_RESET;
		end else begin
			power_up_reset_flag_r <= power_up_reset_flag_r;
		end
	end

	// Assemble the covered bits of the word
	// Parity is computed over exactly the bits the host sees, so the
	// constant zero fields are part of the cover and cost nothing.
	always_comb begin
		parity_cover = '0;
		parity_cover[rtsw_pkg::TRIM_MSB:rtsw_pkg::TRIM_LSB] =
			i_trim_code[rtsw_pkg::TRIM_W-1:0];
		parity_cover[rtsw_pkg::RST_FLAG_POS] = power_up_reset_flag_r;
		parity_cover[rtsw_pkg::UNUSED_LO_MSB:rtsw_pkg::UNUSED_LO_LSB] =
			rtsw_pkg::UNUSED_LO_VALUE;
		// Top unused bit lands one below its word position here
		// top bit zero
		parity_cover[rtsw_pkg::UNUSED_HI_POS-1] = rtsw_pkg::UNUSED_HI_VALUE;
	end

	// Odd parity over the nine covered bits
	rtsw_odd_parity #(
		.WIDTH (rtsw_pkg::WORD_W-1)
	) u_parity (
		.i_bits   (parity_cover),
		.o_parity (parity_bit)
	);

	// Word in host bit order
	always_comb begin
		word_now = '0;
		word_now[rtsw_pkg::UNUSED_LO_MSB:rtsw_pkg::TRIM_LSB] =
			parity_cover[rtsw_pkg::UNUSED_LO_MSB:0];
		word_now[rtsw_pkg::PARITY_POS] = parity_bit;
		word_now[rtsw_pkg::UNUSED_HI_POS] = rtsw_pkg::UNUSED_HI_VALUE;
	end

	// Next values for the host port
	// Reads of other addresses return zero data with no valid, so a
	// parent mux can simply OR the answers of several words together.
	always_comb begin
		rd_data_nxt    = rtsw_pkg::WORD_RESET;
		rd_valid_nxt   = rtsw_pkg::STROBE_RESET;
		wr_refused_nxt = rtsw_pkg::STROBE_RESET;
		if (rd_hit) begin
			// Sampled trim code, no latching of its own
			rd_data_nxt  = word_now;
			rd_valid_nxt = 1'h1;
		end
		if (wr_hit) begin
			wr_refused_nxt = 1'h1;
		end
	end

	// Read answer register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_data_r  <= rtsw_pkg::WORD_RESET;
			rd_valid_r <= rtsw_pkg::STROBE_RESET;
		end else begin
			rd_data_r  <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// Write refusal pulse
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_refused_r <= rtsw_pkg::STROBE_RESET;
		end else begin
			wr_refused_r <= wr_refused_nxt;
		end
	end

	// Live copy of the word for other on-chip users
	// One cycle behind the trim input, like the read path.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			status_word_r <= rtsw_pkg::WORD_RESET;
		end else begin
			status_word_r <= word_now;
		end
	end

	// Outputs straight from flip-flops
	assign o_rd_data             = rd_data_r;
	assign o_rd_valid            = rd_valid_r;
	assign o_wr_refused          = wr_refused_r;
	assign o_status_word         = status_word_r;
	assign o_power_up_reset_flag = power_up_reset_flag_r;

endmodule

`default_nettype wire

// ### verification/rtsw_host_model.sv
// Host model: issues one status word request per falling edge.
// Assumes the block samples requests on rising edges.
`timescale 1ns/100ps
`default_nettype none
module rtsw_host_model (
	input  wire logic               i_clk,  // Bus clock
	output var rtsw_pkg::rtsw_req_s o_req   // Request to the word
);
	// Idle until the first request
	initial o_req = '0;
	// Change after a falling edge, hold a full cycle
	task automatic put(input rtsw_pkg::rtsw_req_s rq);
		@(negedge i_clk);
		o_req = rq;
	endtask
endmodule
`default_nettype wire

// ### verification/rtsw_status_word_sva.sv
// Checker for the status word ports.
// Assumes one clock domain with asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module rtsw_status_word_sva (
	input wire logic                       i_clk,
	input wire logic                       i_rst,
	input wire rtsw_pkg::rtsw_req_s        i_req,
	input wire logic [rtsw_pkg::TRIM_W-1:0] i_trim_code,
	input wire logic [rtsw_pkg::WORD_W-1:0] o_rd_data,
	input wire logic                       o_rd_valid,
	input wire logic                       o_wr_refused,
	input wire logic [rtsw_pkg::WORD_W-1:0] o_status_word,
	input wire logic                       o_power_up_reset_flag
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic hit;  // Access aimed at this word
	assign hit = i_req.addr == rtsw_pkg::RESET_AND_TRIM_STATUS_ADDR;
	property p_rd;
		i_req.rd && hit |=> o_rd_valid && o_rd_data[4:0] == $past(i_trim_code);
	endproperty
	a_rd: assert property (p_rd) else $error("read answer wrong");
	property p_stray;
		!(i_req.rd && hit) |=> !o_rd_valid && o_rd_data == 10'h0;
	endproperty
	a_stray: assert property (p_stray) else $error("stray read answer");
	property p_live;
		!$past(i_rst) |-> o_status_word[4:0] == $past(i_trim_code);
	endproperty
	a_live: assert property (p_live) else $error("live trim wrong");
	property p_flag;
		o_power_up_reset_flag && ($past(i_rst) || o_status_word[5]);
	endproperty
	a_flag: assert property (p_flag) else $error("reset flag low");
	property p_lo;
		o_rd_valid |-> o_rd_data[7:6] == 2'h0;
	endproperty
	a_lo: assert property (p_lo) else $error("unused bits set");
	property p_par;
		o_rd_valid |-> ^o_rd_data;
	endproperty
	a_par: assert property (p_par) else $error("parity even");
	property p_msb;
		!o_rd_data[9] && !o_status_word[9];
	endproperty
	a_msb: assert property (p_msb) else $error("top bit set");
	// write refused, flag kept
	// Flag rather than live word: the word is still zero one edge after reset
	property p_wr;
		i_req.wr && !i_req.rd && hit |=>
			o_wr_refused && o_power_up_reset_flag && $stable(o_power_up_reset_flag);
	endproperty
	a_wr: assert property (p_wr) else $error("write not refused");
	property p_nowr;
		!(i_req.wr && !i_req.rd && hit) |=> !o_wr_refused;
	endproperty
	a_nowr: assert property (p_nowr) else $error("stray write refusal");
endmodule
bind rtsw_status_word rtsw_status_word_sva rtsw_status_word_sva_i(.i_clk(i_clk), .i_rst(i_rst),
	.i_req(i_req), .i_trim_code(i_trim_code), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
	.o_wr_refused(o_wr_refused), .o_status_word(o_status_word),
	.o_power_up_reset_flag(o_power_up_reset_flag));
`default_nettype wire

// ### verification/test_rtsw_status_word.sv
// Testbench for the status word: corners, random traffic, mid-run reset.
// Assumes the host model drives requests; bench drives trim and reset.
`timescale 1ns/100ps
`default_nettype none
module test_rtsw_status_word;
	logic                i_clk, i_rst;       // Clock and reset
	logic [4:0]          trim;               // Factory trim drive
	rtsw_pkg::rtsw_req_s req, prv, rq;       // Requests
	logic [9:0]          rd_data, word;      // Read data, live word
	logic                rd_valid, wr_ref, flag;
	int                  fail_count, check_count;
	localparam logic [6:0] A = rtsw_pkg::RESET_AND_TRIM_STATUS_ADDR;
	initial begin
		i_clk = 1'h0;
		forever #12.5 i_clk = ~i_clk;
	end
	rtsw_host_model rtsw_host_model_i(.i_clk(i_clk), .o_req(req));
	rtsw_status_word rtsw_status_word_i(.i_clk(i_clk), .i_rst(i_rst), .i_req(req),
		.i_trim_code(trim), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.o_wr_refused(wr_ref), .o_status_word(word), .o_power_up_reset_flag(flag));
	// Expected word: parity makes the ones count odd with the flag set
	function automatic logic [9:0] exp_w(input logic [4:0] t);
		return {1'h0, ^t, 2'h0, 1'h1, t};
	endfunction
	task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Answers seen now belong to the previous request and current trim
	task automatic step(input rtsw_pkg::rtsw_req_s r, input logic [4:0] t);
		logic h;
		rtsw_host_model_i.put(r);
		h = prv.addr === A;
		chk("rd_valid", 10'(rd_valid), 10'(prv.rd && h));
		chk("rd_data", rd_data, (prv.rd && h) ? exp_w(trim) : 10'h0);
		chk("wr_refused", 10'(wr_ref), 10'(prv.wr && !prv.rd && h));
		chk("status_word", word, exp_w(trim));
		chk("flag", 10'(flag), 10'h1);
		prv = r;
		trim = t;
	endtask
	// Reset spans exactly two rising edges, at the start and mid-run alike
	task automatic do_reset();
		i_rst = 1'h1;
		rtsw_host_model_i.put('0);
		@(negedge i_clk);
		chk("rst_flag", 10'(flag), 10'h1);
		chk("rst_word", word, 10'h0);
		i_rst = 1'h0;
		prv = '0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		i_rst = 1'h1;
		trim = 5'h00;
		prv = '0;
		fail_count = 0;
		check_count = 0;
		void'($urandom(32'h5fab67b2));
		do_reset();
		step('{1'h1, 1'h0, A}, 5'h1f);
		step('{1'h1, 1'h0, A}, 5'h00);
		step('{1'h0, 1'h1, A}, 5'h15);
		step('{1'h1, 1'h1, A}, 5'h0a);
		step('{1'h1, 1'h0, 7'h18}, 5'h03);
		step('{1'h0, 1'h1, 7'h1a}, 5'h00);
		$display("corner test done");
		repeat (300) begin
			rq = '{1'($urandom), 1'($urandom), ($urandom_range(1) != 0) ? A : 7'($urandom)};
			step(rq, 5'($urandom));
		end
		$display("random test done");
		do_reset();
		step('{1'h1, 1'h0, A}, 5'h07);
		step('0, 5'h00);
		$display("reset test done");
		wrap_up();
	end
endmodule
`default_nettype wire
